// ===== logic/vpp_consts.vh
// constants for the video processor port block: offsets, field positions, timing
// included by bare name from the top-level design file under logic/; the gray converter does not include it
`ifndef VPP_CONSTS_VH
`define VPP_CONSTS_VH
`define VPP_LUMA_DELAY_ADDR     8'h0F
`define VPP_LUMA_DELAY_RESET    16'h0080
`define VPP_LD_BYPASS_BIT       7
`define VPP_LD_SEL_HI           6
`define VPP_LD_SEL_LO           4
`define VPP_LD_CENTER           4
`define VPP_PLL_WORD_BITS       12
`define VPP_PLL_SEL_BITS        3
`define VPP_PLL_TUNE_BITS       9
`define VPP_PLL_SEL_RESET       3'h0
`define VPP_LINE_PERIOD_NS      64000
`define VPP_CLK_PERIOD_NS       10
`define VPP_DCLK_DIV            4
`endif

// ===== logic/vpp_gray2bin.v
// gray to binary converter for the incoming video sample
// input is already registered in the main clock domain
`timescale 1ns/10ps
module vpp_gray2bin #(
  parameter W = 7
) (
  // conversion
  input  wire [W-1:0] gray_i,
  output wire [W-1:0] bin_o
);
  genvar k;
  assign bin_o[W-1] = gray_i[W-1];
  generate
    for (k = W-2; k >= 0; k = k - 1)
    begin : g_bit
      assign bin_o[k] = bin_o[k+1] ^ gray_i[k];
    end
  endgenerate
endmodule

// ===== logic/vpp_top.v
// video processor pin interface: gray video in, luma/chroma out, pll serial word out
// assumes the video and sync pins are asynchronous to clk_sys_i; datapath filters are outside this block
// Notes on behaviour
// - luma delay bits 7..4, bit7 bypasses delay
// - colour key active low, low is pulse
// - 7-bit gray video word, bit0 is LSB
// - vblank low; measurements only inside vblank
// - disable high tristates luma and chroma outputs
// - reset low returns to initial state
// - pll data clock is main clock / 4
// - shift 12-bit pll word on data output
// - 4-bit chroma bus, bit0 carries mux sync
// - 8-bit luminance word, bit0 is LSB
// - sensitivity high for cutoff, low white
// - selector routes beam or photo input
// - convert gray video to binary first
// - three select bits, nine tuning bits
// - new pll word each line start
`timescale 1ns/10ps
`include "vpp_consts.vh"
module vpp_top #(
  parameter LINE_CYCLES = `VPP_LINE_PERIOD_NS / `VPP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  // video and sync pins
  input  wire [6:0]  video_in_i,
  input  wire        color_key_n_i,
  input  wire        vblank_n_i,
  input  wire        outputs_disable_i,
  // luma delay register load
  input  wire        reg_wr_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  // pll tuning from the phase loop
  input  wire [2:0]  pll_osc_sel_i,
  input  wire [8:0]  pll_tune_i,
  // luma and chroma outputs
  output reg  [7:0]  luma_out_o,
  output reg  [7:0]  luma_oe_o,
  output reg  [3:0]  chroma_out_o,
  output reg  [3:0]  chroma_oe_o,
  // pll serial link
  output reg         pll_dclk_o,
  output reg         pll_data_o,
  // measurement control
  output reg         beam_sense_switch_o,
  output reg         photo_sense_switch_o,
  output reg         high_sens_o
);
  localparam LD_DEPTH = 9;
  localparam integer LINE_LAST_I = LINE_CYCLES - 1;
  localparam [15:0] LINE_LAST = LINE_LAST_I[15:0];
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SHIFT = 2'h1;
  localparam [1:0] ST_MS_CUTOFF = 2'h0;
  localparam [1:0] ST_MS_WHITE = 2'h1;
  localparam [1:0] ST_MS_PHOTO = 2'h2;
  localparam [1:0] ST_MS_DONE = 2'h3;

  // three-stage synchronisers; the second and third stage must agree
  reg  [9:0]  s1_ff, s2_ff, s3_ff;
  reg  [9:0]  pin_ff;
  integer     i;
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1_ff  <= 10'h3E0;
      s2_ff  <= 10'h3E0;
      s3_ff  <= 10'h3E0;
      pin_ff <= 10'h3E0;
    end
    else
    begin
      s1_ff <= {outputs_disable_i, vblank_n_i, color_key_n_i, video_in_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < 10; i = i + 1)
        if (s2_ff[i] == s3_ff[i])
          pin_ff[i] <= s3_ff[i];
    end
  end
  wire [6:0] gray_w   = pin_ff[6:0];
  wire       key_w    = ~pin_ff[7];
  wire       vblank_w = ~pin_ff[8];
  wire       dis_w    = pin_ff[9];

  // gray to binary before the luma path
  wire [6:0] bin_w;
  vpp_gray2bin #(
    .W (7)
  ) u_g2b (
    .gray_i (gray_w),
    .bin_o  (bin_w)
  );

  // luma delay register, write only
  reg  [15:0] ld_ff;
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ld_ff <= `VPP_LUMA_DELAY_RESET;
    else if (reg_wr_i && reg_addr_i == `VPP_LUMA_DELAY_ADDR)
      ld_ff <= reg_wdata_i;
  end

  // delay line: tap 4 is nominal, taps 0..8 give -4..+4
  reg  [7:0]  dl_ff [0:LD_DEPTH-1];
  reg  [3:0]  tap;
  integer     j;
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (j = 0; j < LD_DEPTH; j = j + 1)
        dl_ff[j] <= 8'h00;
    end
    else
    begin
      dl_ff[0] <= {1'b0, bin_w} + {1'b0, bin_w};
      for (j = 1; j < LD_DEPTH; j = j + 1)
        dl_ff[j] <= dl_ff[j-1];
    end
  end
  // the bypass bit outranks the select bits; a lower tap is a younger sample,
  // so negative codes land below the centre tap
  always @*
  begin
    if (ld_ff[`VPP_LD_BYPASS_BIT])
      tap = 4'd`VPP_LD_CENTER;
    else if (ld_ff[`VPP_LD_SEL_HI])
      tap = {2'b00, ld_ff[5:4]} + 4'h5;
    else
      tap = {2'b00, ld_ff[5:4]};
  end

  // chroma mux: slot 0 sync marker on bit 0, then R-Y, B-Y, alignment nibbles
  reg  [1:0]  slot_ff;
  reg  [3:0]  nxt_chroma;
  reg  [7:0]  meas_ff;
  always @*
  begin
    case (slot_ff)
      2'h0:    nxt_chroma = 4'h1;
      2'h1:    nxt_chroma = bin_w[6:3];
      2'h2:    nxt_chroma = bin_w[3:0];
      default: nxt_chroma = key_w ? 4'h0 : meas_ff[3:0];
    endcase
  end

  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      slot_ff      <= 2'h0;
      luma_out_o   <= 8'h00;
      chroma_out_o <= 4'h0;
      luma_oe_o    <= 8'h00;
      chroma_oe_o  <= 4'h0;
    end
    else
    begin
      slot_ff      <= slot_ff + 2'h1;
      luma_out_o   <= key_w ? 8'h00 : dl_ff[tap];
      chroma_out_o <= nxt_chroma;
      luma_oe_o    <= {8{~dis_w}};
      chroma_oe_o  <= {4{~dis_w}};
    end
  end

  // line timer starts each pll word
  reg  [15:0] line_ff;
  wire        line_start = (line_ff == LINE_LAST);
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      line_ff <= 16'h0000;
    else if (line_start)
      line_ff <= 16'h0000;
    else
      line_ff <= line_ff + 16'h0001;
  end

  // data clock divider: phase 0,1 high, 2,3 low; data changes only while it is high
  // the clock stands high between words, so the receiver sees exactly twelve falls
  // and takes the word over on the twelfth fall
  reg  [1:0]  ph_ff;
  reg  [1:0]  st_ff;
  reg  [11:0] sh_ff;
  reg  [3:0]  bit_ff;
  reg         start_ff;
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ph_ff      <= 2'h0;
      pll_dclk_o <= 1'b1;
      pll_data_o <= 1'b0;
      st_ff      <= ST_IDLE;
      sh_ff      <= 12'h000;
      bit_ff     <= 4'h0;
      start_ff   <= 1'b0;
    end
    else
    begin
      ph_ff      <= ph_ff + 2'h1;
      if (st_ff == ST_SHIFT && bit_ff != 4'h0)
        pll_dclk_o <= (ph_ff == 2'h3) || (ph_ff == 2'h0);
      else
        pll_dclk_o <= 1'b1;
      if (line_start)
        start_ff <= 1'b1;
      case (st_ff)
        ST_IDLE:
        begin
          if (start_ff && ph_ff == 2'h3)
          begin
            start_ff   <= line_start;
            sh_ff      <= {pll_osc_sel_i, pll_tune_i};
            bit_ff     <= 4'h0;
            st_ff      <= ST_SHIFT;
          end
        end
        default:
        begin
          if (ph_ff == 2'h3)
          begin
            if (bit_ff == `VPP_PLL_WORD_BITS)
              st_ff <= ST_IDLE;
            else
            begin
              pll_data_o <= sh_ff[11];
              sh_ff      <= {sh_ff[10:0], 1'b0};
              bit_ff     <= bit_ff + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // measurements run only during vertical blanking
  reg  [1:0]  ms_ff;
  reg         vb_d_ff;
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ms_ff                <= ST_MS_DONE;
      vb_d_ff              <= 1'b0;
      meas_ff              <= 8'h00;
      beam_sense_switch_o  <= 1'b0;
      photo_sense_switch_o <= 1'b0;
      high_sens_o          <= 1'b0;
    end
    else
    begin
      vb_d_ff <= vblank_w;
      if (!vblank_w)
      begin
        ms_ff                <= ST_MS_DONE;
        beam_sense_switch_o  <= 1'b0;
        photo_sense_switch_o <= 1'b0;
        high_sens_o          <= 1'b0;
      end
      else
      begin
        if (!vb_d_ff)
          ms_ff <= ST_MS_CUTOFF;
        else if (line_start && ms_ff != ST_MS_DONE)
          ms_ff <= ms_ff + 2'h1;
        case (ms_ff)
          ST_MS_CUTOFF:
          begin
            beam_sense_switch_o  <= 1'b1;
            photo_sense_switch_o <= 1'b0;
            high_sens_o          <= 1'b1;
          end
          ST_MS_WHITE:
          begin
            beam_sense_switch_o  <= 1'b1;
            photo_sense_switch_o <= 1'b0;
            high_sens_o          <= 1'b0;
          end
          ST_MS_PHOTO:
          begin
            beam_sense_switch_o  <= 1'b0;
            photo_sense_switch_o <= 1'b1;
            high_sens_o          <= 1'b0;
          end
          default:
          begin
            beam_sense_switch_o  <= 1'b0;
            photo_sense_switch_o <= 1'b0;
            high_sens_o          <= 1'b0;
          end
        endcase
        meas_ff <= {1'b0, bin_w};
      end
    end
  end
endmodule

// ===== sim/tb_vpp_top.sv
// bench for vpp_top: delay codes, gray decode, pll word per line, measurement walk
// all pins driven by the bench; pll receiver model on the serial link
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_vpp_top;
  localparam LC = 100;
  reg        clk_sys_i = 0, nrst_i = 0, color_key_n_i = 1, vblank_n_i = 1, outputs_disable_i = 0, reg_wr_i = 0;
  reg [6:0]  video_in_i = 0;
  reg [7:0]  reg_addr_i = 0;
  reg [15:0] reg_wdata_i = 0;
  reg [2:0]  pll_osc_sel_i = 0;
  reg [8:0]  pll_tune_i = 0;
  wire [7:0] luma_out_o, luma_oe_o;
  wire [3:0] chroma_out_o, chroma_oe_o;
  wire       pll_dclk_o, pll_data_o, beam_sense_switch_o, photo_sense_switch_o, high_sens_o;
  wire [11:0] rx_word;
  integer    hits;
  int        err_count = 0, n_checks = 0, n0, n, h0, wh, ph;
  logic [6:0] g;
  vpp_top #(.LINE_CYCLES(LC)) u_vpp_top (.clk_sys_i, .nrst_i, .video_in_i, .color_key_n_i, .vblank_n_i,
    .outputs_disable_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .pll_osc_sel_i, .pll_tune_i, .luma_out_o,
    .luma_oe_o, .chroma_out_o, .chroma_oe_o, .pll_dclk_o, .pll_data_o, .beam_sense_switch_o,
    .photo_sense_switch_o, .high_sens_o);
  vpp_pll_rx u_vpp_pll_rx (.pll_dclk_i(pll_dclk_o), .pll_data_i(pll_data_o),
    .expect_i({pll_osc_sel_i, pll_tune_i}), .word_o(rx_word), .hits_o(hits));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // gray to binary, doubled to the 8-bit luma scale
  function [7:0] ref_luma(input [6:0] gr);
    integer i;
    ref_luma[7] = gr[6];
    for (i = 5; i >= 0; i--)
      ref_luma[i + 1] = ref_luma[i + 2] ^ gr[i];
    ref_luma[0] = 1'b0;
  endfunction
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 0;
  endtask
  // cycles from a video step to the stepped luma value
  task lat(input [7:0] a, input [15:0] d, output int c);
    wr(a, d);
    video_in_i <= 7'h00;
    repeat (30) @(posedge clk_sys_i);
    video_in_i <= 7'h40;
    c = 0;
    while (luma_out_o !== 8'hFE && c < 80)
    begin
      @(posedge clk_sys_i);
      c++;
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_count++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(52930));
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1;
    lat(8'h0F, 16'h0080, n0);
    `CHK("luma step", 8'hFE, luma_out_o)
    for (int k = 0; k < 8; k++)
    begin
      lat(8'h0F, {9'h000, k[2:0], 4'h0}, n);
      `CHK("delay", n0 + (k > 3 ? k - 3 : k - 4), n)
    end
    lat(8'h0E, 16'h0000, n);
    `CHK("unmapped", n0 + 4, n)
    wr(8'h0F, 16'h0080);
    $display("delay test done");
    repeat (20)
    begin
      g = 7'($urandom);
      video_in_i <= g;
      repeat (20) @(posedge clk_sys_i);
      `CHK("gray", ref_luma(g), luma_out_o)
    end
    $display("gray test done");
    g = 7'($urandom);
    pll_osc_sel_i <= {1'b1, g[1:0]};
    pll_tune_i <= 9'($urandom);
    repeat (2 * LC) @(posedge clk_sys_i);
    h0 = hits;
    repeat (3 * LC) @(posedge clk_sys_i);
    `CHK("pll words", 3, hits - h0)
    $display("pll test done");
    wr(8'h0F, 16'h0000);
    nrst_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    `CHK("reset luma", 8'h00, luma_out_o)
    `CHK("reset oe", 8'h00, luma_oe_o)
    `CHK("reset dclk", 1'b1, pll_dclk_o)
    nrst_i <= 1;
    lat(8'h0E, 16'h0000, n);
    `CHK("reset delay", n0, n)
    $display("reset test done");
    video_in_i <= 7'h40;
    vblank_n_i <= 0;
    outputs_disable_i <= 1;
    color_key_n_i <= 0;
    wh = 0;
    ph = 0;
    for (int k = 0; k < 4 * LC; k++)
    begin
      @(posedge clk_sys_i);
      wh += beam_sense_switch_o && !high_sens_o;
      ph += photo_sense_switch_o;
    end
    `CHK("white cycles", LC, wh)
    `CHK("photo cycles", LC, ph)
    `CHK("oe off", 8'h00, luma_oe_o)
    `CHK("key luma", 8'h00, luma_out_o)
    `CHK("chroma oe off", 4'h0, chroma_oe_o)
    n = 0;
    while (chroma_out_o !== 4'h1 && n < 4)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    @(negedge clk_sys_i);
    `CHK("chroma r-y", 4'hF, chroma_out_o)
    @(negedge clk_sys_i);
    `CHK("chroma b-y", 4'hF, chroma_out_o)
    @(negedge clk_sys_i);
    `CHK("chroma align", 4'h0, chroma_out_o)
    @(posedge clk_sys_i);
    vblank_n_i <= 1;
    outputs_disable_i <= 0;
    color_key_n_i <= 1;
    repeat (20) @(posedge clk_sys_i);
    `CHK("oe on", 8'hFF, luma_oe_o)
    `CHK("chroma oe on", 4'hF, chroma_oe_o)
    $display("measure test done");
    tally_and_finish;
  end
endmodule

// ===== sim/vpp_pll_rx.sv
// clock generator side of the pll link, behavioural
// counts each time the expected 12-bit word stands whole in its register
`timescale 1ns/10ps
module vpp_pll_rx (
  // pll link
  input  wire        pll_dclk_i,
  input  wire        pll_data_i,
  // bench side
  input  wire [11:0] expect_i,
  output reg  [11:0] word_o,
  output integer     hits_o
);
  integer cnt;
  initial word_o = 12'h000;
  initial hits_o = 0;
  initial cnt = 0;
  // capture on the falling edge only; the word is taken over after twelve bits,
  // so a sender that clocks one bit too many or too few misaligns every later word
  always @(negedge pll_dclk_i)
  begin
    word_o = {word_o[10:0], pll_data_i};
    cnt = cnt + 1;
    if (cnt == 12)
    begin
      cnt = 0;
      if (word_o === expect_i)
        hits_o = hits_o + 1;
    end
  end
endmodule

// ===== sim/vpp_top_asserts.sv
// checker for vpp_top: pll link timing, output enables, measurement pins
// sees only the top ports and is bound in below
`timescale 1ns/10ps
module vpp_top_chk (
  // clock, reset and pins
  input wire       clk_sys_i,
  input wire       nrst_i,
  input wire       color_key_n_i,
  input wire       vblank_n_i,
  input wire       outputs_disable_i,
  // outputs watched
  input wire [7:0] luma_out_o,
  input wire [7:0] luma_oe_o,
  input wire [3:0] chroma_oe_o,
  input wire       pll_dclk_o,
  input wire       pll_data_o,
  input wire       beam_sense_switch_o,
  input wire       photo_sense_switch_o,
  input wire       high_sens_o
);
  reg [4:0] key_cnt_ff;
  // saturating count of key-low cycles; covers sync plus the longest delay tap
  always @(posedge clk_sys_i or negedge nrst_i)
    if (!nrst_i)
      key_cnt_ff <= 5'h00;
    else if (color_key_n_i)
      key_cnt_ff <= 5'h00;
    else if (key_cnt_ff != 5'h1F)
      key_cnt_ff <= key_cnt_ff + 5'h01;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_dclk_quarter: assert property (
    $fell(pll_dclk_o) |=> !pll_dclk_o ##1 pll_dclk_o [*2]) else $error("data clock not clk/4");
  a_data_clk_high: assert property (
    !$stable(pll_data_o) |-> pll_dclk_o) else $error("pll data moved while data clock low");
  a_oe_off: assert property (
    outputs_disable_i [*6] |-> luma_oe_o == 8'h00 && chroma_oe_o == 4'h0) else $error("outputs still driven");
  a_oe_on: assert property (
    (!outputs_disable_i) [*6] |-> luma_oe_o == 8'hFF && chroma_oe_o == 4'hF) else $error("outputs not driven");
  a_key_blank: assert property (
    key_cnt_ff >= 5'h14 |-> luma_out_o == 8'h00) else $error("luma not blanked by key");
  a_vb_idle: assert property (
    vblank_n_i [*6] |-> !(beam_sense_switch_o || photo_sense_switch_o || high_sens_o)) else $error("measure outside vblank");
  a_sens_beam: assert property (
    high_sens_o |-> beam_sense_switch_o && !photo_sense_switch_o) else $error("high sensitivity off beam input");
  a_one_input: assert property (
    !(beam_sense_switch_o && photo_sense_switch_o)) else $error("both converter inputs selected");
  a_luma_even: assert property (
    luma_out_o[0] == 1'b0) else $error("luma lsb set");
endmodule
bind vpp_top vpp_top_chk u_vpp_top_chk (.clk_sys_i, .nrst_i, .color_key_n_i, .vblank_n_i, .outputs_disable_i,
  .luma_out_o, .luma_oe_o, .chroma_oe_o, .pll_dclk_o, .pll_data_o, .beam_sense_switch_o, .photo_sense_switch_o,
  .high_sens_o);
